// >>> dtcu_top.sv
// Dual timer/counter unit with Avalon-MM register slave
//
// Operation
// - Timer function counts one per six clocks
// - Counter counts sampled high-then-low pin transitions
// - Count updates machine cycle after edge detect
// - Per-timer function select bit and mode field
// - Mode 0 is 13-bit counter, low five bits
// - Wrap to zero sets overflow flag
// - Run bit and (gate clear or pin high)
// - Setting run bit leaves counts unchanged
// - Gate bits at mode bits seven and three
// - Mode 1 uses all sixteen bits
// - Mode 2 reloads low from high byte
// - Timer 1 mode 3 holds it stopped
// - Timer 0 mode 3 low byte keeps controls
// - Split high byte uses timer 1 run, flag
// - Split mode: timer 1 runs outside mode 3
`include "dtcu_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module dtcu_top #(
  parameter logic [2:0] MC_LAST = `DTCU_MC_LAST
) (
  input  wire logic        i_mclk,
  input  wire logic        i_rst,
  input  wire logic [9:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0]  i_avs_byteenable,
  output logic      [31:0] o_avs_readdata,
  output logic             o_avs_waitrequest,
  input  wire logic        i_first_count_pin,
  input  wire logic        i_second_count_pin,
  input  wire logic        i_first_gate_pin,
  input  wire logic        i_second_gate_pin,
  input  wire logic [3:0]  i_vec_ack,
  output logic             o_irq,
  output logic             o_second_timer_ovf
);

  function automatic logic addr_hit(input logic [9:0] addr,
                                    input logic [7:0] idx);
    addr_hit = (addr[9:2] == idx);
  endfunction : addr_hit

  function automatic dtcu_pkg::dtcu_step_t dtcu_step(
    input dtcu_pkg::dtcu_mode_t mode,
    input logic [7:0]           th,
    input logic [7:0]           tl
  );
    logic [13:0] s13;
    logic [16:0] s16;
    logic [8:0]  s8;
    s13 = {1'b0, th, tl[4:0]} + 14'h0001;
    s16 = {1'b0, th, tl} + 17'h00001;
    s8  = {1'b0, tl} + 9'h001;
    unique case (mode)
      dtcu_pkg::DTCU_MODE_13BIT:
        // Upper three low-byte bits are left as they stand
        dtcu_step = {s13[13], s13[12:5], tl[7:5], s13[4:0]};
      dtcu_pkg::DTCU_MODE_16BIT:
        dtcu_step = s16;
      dtcu_pkg::DTCU_MODE_RELOAD:
        dtcu_step = {s8[8], th, s8[8] ? th : s8[7:0]};
      dtcu_pkg::DTCU_MODE_SPLIT:
        dtcu_step = {s8[8], th, s8[7:0]};
    endcase
  endfunction : dtcu_step

  // Bus slave: one wait cycle, then the answer
  logic        ack_reg;
  logic [31:0] rdata_reg;
  wire  logic  bus_req = i_avs_read | i_avs_write;
  wire  logic  acc_wr  = i_avs_write & ack_reg & i_avs_byteenable[0];
  wire  logic [7:0] wdat = i_avs_writedata[7:0];

  assign o_avs_waitrequest = bus_req & ~ack_reg;
  assign o_avs_readdata    = rdata_reg;

  wire logic sel_tcs   = addr_hit(i_avs_address, `DTCU_IDX_TCS);
  wire logic sel_tmode = addr_hit(i_avs_address, `DTCU_IDX_TMODE);
  wire logic sel_t0lo  = addr_hit(i_avs_address, `DTCU_IDX_T0LO);
  wire logic sel_t1lo  = addr_hit(i_avs_address, `DTCU_IDX_T1LO);
  wire logic sel_t0hi  = addr_hit(i_avs_address, `DTCU_IDX_T0HI);
  wire logic sel_t1hi  = addr_hit(i_avs_address, `DTCU_IDX_T1HI);
  wire logic sel_irqst = addr_hit(i_avs_address, `DTCU_IDX_IRQST);
  wire logic sel_irqmk = addr_hit(i_avs_address, `DTCU_IDX_IRQMSK);

  // Machine cycle prescaler
  logic [2:0] presc_reg;
  wire  logic mc_tick = (presc_reg == MC_LAST);

  // Control and count state
  logic [7:0] tmode_reg;
  logic [1:0] tf_reg;
  logic [1:0] tr_reg;
  logic [1:0] ie_reg;
  logic [1:0] it_reg;
  logic [7:0] tl0_reg;
  logic [7:0] th0_reg;
  logic [7:0] tl1_reg;
  logic [7:0] th1_reg;
  logic [3:0] st_reg;
  logic [3:0] mask_reg;
  logic [1:0] smp_reg;
  logic [1:0] old_reg;
  logic [1:0] gpin_reg;
  logic       t1ovf_reg;

  dtcu_pkg::dtcu_tcfg_t cfg0;
  dtcu_pkg::dtcu_tcfg_t cfg1;
  assign cfg0 = dtcu_pkg::dtcu_tcfg_t'(
                  tmode_reg[`DTCU_TMODE_T0_MSB:`DTCU_TMODE_T0_LSB]);
  assign cfg1 = dtcu_pkg::dtcu_tcfg_t'(
                  tmode_reg[`DTCU_TMODE_T1_MSB:`DTCU_TMODE_T1_LSB]);

  // Count pins are sampled once per machine cycle; an edge found from
  // the last two samples counts at the next tick, two cycles in all
  wire logic [1:0] cnt_edge = old_reg & ~smp_reg;
  wire logic [1:0] gate_pin = {i_second_gate_pin, i_first_gate_pin};
  wire logic [1:0] gate_fall = gpin_reg & ~gate_pin;

  wire logic t0_split = (cfg0.mode == dtcu_pkg::DTCU_MODE_SPLIT);
  wire logic t1_halt  = (cfg1.mode == dtcu_pkg::DTCU_MODE_SPLIT);

  wire logic en0 = tr_reg[0] & (~cfg0.gate | i_first_gate_pin);
  // With timer 0 split, timer 1's run bit belongs to the high byte
  wire logic run1 = t0_split ? 1'b1 : tr_reg[1];
  wire logic en1  = run1 & ~t1_halt &
                    (~cfg1.gate | i_second_gate_pin);

  wire logic inc0  = mc_tick & en0 & (~cfg0.ct | cnt_edge[0]);
  wire logic inc1  = mc_tick & en1 & (~cfg1.ct | cnt_edge[1]);
  wire logic inc0h = mc_tick & t0_split & tr_reg[1];

  dtcu_pkg::dtcu_step_t step0;
  dtcu_pkg::dtcu_step_t step1;
  assign step0 = dtcu_step(cfg0.mode, th0_reg, tl0_reg);
  assign step1 = dtcu_step(cfg1.mode, th1_reg, tl1_reg);

  wire logic [8:0] th0_inc = {1'b0, th0_reg} + 9'h001;
  wire logic ovf0  = inc0 & step0.ovf;
  wire logic ovf1  = inc1 & step1.ovf;
  wire logic ovf0h = inc0h & th0_inc[8];
  // Timer 1 overflow stays off its flag while timer 0 is split
  wire logic [1:0] tf_set = {t0_split ? ovf0h : ovf1, ovf0};

  wire logic wr_tcs = acc_wr & sel_tcs;
  wire logic [1:0] wd_tf = {wdat[`DTCU_TCS_TF1], wdat[`DTCU_TCS_TF0]};
  wire logic [1:0] wd_tr = {wdat[`DTCU_TCS_TR1], wdat[`DTCU_TCS_TR0]};
  wire logic [1:0] wd_ie = {wdat[`DTCU_TCS_IE1], wdat[`DTCU_TCS_IE0]};
  wire logic [1:0] wd_it = {wdat[`DTCU_TCS_IT1], wdat[`DTCU_TCS_IT0]};

  // Hardware set wins over any clear in the same cycle
  wire logic [1:0] tf_next = tf_set |
    (wr_tcs ? wd_tf : (tf_reg & ~i_vec_ack[1:0]));
  wire logic [1:0] ie_set  = (it_reg & gate_fall) | (~it_reg & ~gate_pin);
  wire logic [1:0] ie_next = ie_set |
    (wr_tcs ? wd_ie : (ie_reg & ~i_vec_ack[3:2]));
  wire logic [1:0] tr_next = wr_tcs ? wd_tr : tr_reg;
  wire logic [1:0] it_next = wr_tcs ? wd_it : it_reg;

  // Software writes take priority over counting in the same cycle
  wire logic [7:0] tl0_next = (acc_wr & sel_t0lo) ? wdat :
                              inc0 ? step0.tl : tl0_reg;
  wire logic [7:0] th0_next = (acc_wr & sel_t0hi) ? wdat :
                              inc0h ? th0_inc[7:0] :
                              (inc0 & ~t0_split) ? step0.th :
                              th0_reg;
  wire logic [7:0] tl1_next = (acc_wr & sel_t1lo) ? wdat :
                              inc1 ? step1.tl : tl1_reg;
  wire logic [7:0] th1_next = (acc_wr & sel_t1hi) ? wdat :
                              inc1 ? step1.th : th1_reg;

  wire logic [3:0] st_ev = {ie_set, tf_set};
  wire logic [3:0] st_next = st_ev |
    ((acc_wr & sel_irqst) ? (st_reg & ~wdat[3:0]) : st_reg);
  wire logic [3:0] mask_next = (acc_wr & sel_irqmk) ? wdat[3:0] : mask_reg;
  wire logic [7:0] tmode_next = (acc_wr & sel_tmode) ? wdat : tmode_reg;

  wire logic [7:0] tcs_byte = {tf_reg[1], tr_reg[1], tf_reg[0], tr_reg[0],
                               ie_reg[1], it_reg[1], ie_reg[0], it_reg[0]};
  wire logic [7:0] rd_byte = sel_tcs   ? tcs_byte  :
                             sel_tmode ? tmode_reg :
                             sel_t0lo  ? tl0_reg   :
                             sel_t1lo  ? tl1_reg   :
                             sel_t0hi  ? th0_reg   :
                             sel_t1hi  ? th1_reg   :
                             sel_irqst ? {4'h0, st_reg}   :
                             sel_irqmk ? {4'h0, mask_reg} : 8'h00;

  assign o_irq = |(st_reg & mask_reg);
  assign o_second_timer_ovf = t1ovf_reg;

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      ack_reg   <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      presc_reg <= 3'h0;
    end else begin
      ack_reg   <= bus_req & ~ack_reg;
      // Read data is caught during the wait cycle and stands after it
      rdata_reg <= (i_avs_read & ~ack_reg) ? {24'h00_0000, rd_byte}
                                           : rdata_reg;
      presc_reg <= mc_tick ? 3'h0 : presc_reg + 3'h1;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      smp_reg  <= 2'h0;
      old_reg  <= 2'h0;
      gpin_reg <= 2'h0;
    end else begin
      gpin_reg <= gate_pin;
      if (mc_tick) begin
        smp_reg <= {i_second_count_pin, i_first_count_pin};
        old_reg <= smp_reg;
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      tmode_reg <= `DTCU_RST_BYTE;
      tf_reg    <= 2'h0;
      tr_reg    <= 2'h0;
      ie_reg    <= 2'h0;
      it_reg    <= 2'h0;
      tl0_reg   <= `DTCU_RST_BYTE;
      th0_reg   <= `DTCU_RST_BYTE;
      tl1_reg   <= `DTCU_RST_BYTE;
      th1_reg   <= `DTCU_RST_BYTE;
      st_reg    <= `DTCU_RST_IRQ;
      mask_reg  <= `DTCU_RST_IRQ;
      t1ovf_reg <= 1'b0;
    end else begin
      tmode_reg <= tmode_next;
      tf_reg    <= tf_next;
      tr_reg    <= tr_next;
      ie_reg    <= ie_next;
      it_reg    <= it_next;
      tl0_reg   <= tl0_next;
      th0_reg   <= th0_next;
      tl1_reg   <= tl1_next;
      th1_reg   <= th1_next;
      st_reg    <= st_next;
      mask_reg  <= mask_next;
      t1ovf_reg <= ovf1;
    end
  end

  // Checks

  AST_PRESCALE: assert property (@(posedge i_mclk) disable iff (i_rst)
    mc_tick |=> !mc_tick [*5] ##1 mc_tick)
    else $error("machine cycle is not six clocks");

  AST_MODE1_STEP: assert property (@(posedge i_mclk) disable iff (i_rst)
    (inc0 && cfg0.mode == dtcu_pkg::DTCU_MODE_16BIT && !acc_wr) |=>
      ({th0_reg, tl0_reg} == $past({th0_reg, tl0_reg}) + 16'h0001))
    else $error("timer 0 mode 1 did not step by one");

  AST_NO_EDGE_HOLD: assert property (@(posedge i_mclk) disable iff (i_rst)
    (mc_tick && cfg0.ct && !cnt_edge[0] && !t0_split && !acc_wr) |=>
      $stable({th0_reg, tl0_reg}))
    else $error("counter advanced without a falling edge");

  AST_EDGE_LATENCY: assert property (@(posedge i_mclk) disable iff (i_rst)
    (mc_tick && smp_reg[1] && !i_second_count_pin && cfg1.ct && en1 &&
     cfg1.mode == dtcu_pkg::DTCU_MODE_16BIT && !acc_wr) ##6
      (!acc_wr && $stable(tmode_reg) && $stable(tr_reg)) |=>
      ({th1_reg, tl1_reg} != $past({th1_reg, tl1_reg}, 7)))
    else $error("falling edge not counted in next machine cycle");

  AST_MODE0_WRAP: assert property (@(posedge i_mclk) disable iff (i_rst)
    (inc0 && cfg0.mode == dtcu_pkg::DTCU_MODE_13BIT &&
     th0_reg == 8'hff && tl0_reg[4:0] == 5'h1f && !acc_wr) |=>
      (tf_reg[0] && th0_reg == 8'h00 && tl0_reg[4:0] == 5'h00))
    else $error("mode 0 wrap did not clear count and set flag");

  AST_RELOAD: assert property (@(posedge i_mclk) disable iff (i_rst)
    (inc1 && cfg1.mode == dtcu_pkg::DTCU_MODE_RELOAD && !t0_split &&
     tl1_reg == 8'hff && !acc_wr) |=>
      (tl1_reg == $past(th1_reg) && $stable(th1_reg) && st_reg[1]))
    else $error("mode 2 reload failed");

  AST_T1_STOPPED: assert property (@(posedge i_mclk) disable iff (i_rst)
    (t1_halt && !acc_wr) |=> $stable({th1_reg, tl1_reg}))
    else $error("timer 1 counted in mode 3");

  AST_GATE_LOW: assert property (@(posedge i_mclk) disable iff (i_rst)
    (cfg0.gate && !i_first_gate_pin && !t0_split && !acc_wr) |=>
      $stable({th0_reg, tl0_reg}))
    else $error("gated timer 0 counted with gate pin low");

  AST_SPLIT_HIGH: assert property (@(posedge i_mclk) disable iff (i_rst)
    (mc_tick && t0_split && tr_reg[1] && th0_reg == 8'hff && !acc_wr) |=>
      (tf_reg[1] && th0_reg == 8'h00))
    else $error("split high byte overflow did not set timer 1 flag");

  AST_FLAG_ACK: assert property (@(posedge i_mclk) disable iff (i_rst)
    (i_vec_ack[0] && !tf_set[0] && !wr_tcs) |=> !tf_reg[0])
    else $error("vectoring did not clear timer 0 flag");

  AST_BUS_ANSWER: assert property (@(posedge i_mclk) disable iff (i_rst)
    (bus_req && o_avs_waitrequest) |=> !o_avs_waitrequest)
    else $error("bus answer took more than one wait cycle");

endmodule : dtcu_top

`default_nettype wire

// >>> dtcu_regs.svh
// Register indices, field positions, reset values and timing counts
`ifndef DTCU_REGS_SVH
`define DTCU_REGS_SVH

// Register indices; byte address is four times the index
`define DTCU_IDX_TCS     8'h88
`define DTCU_IDX_TMODE   8'h89
`define DTCU_IDX_T0LO    8'h8a
`define DTCU_IDX_T1LO    8'h8b
`define DTCU_IDX_T0HI    8'h8c
`define DTCU_IDX_T1HI    8'h8d
`define DTCU_IDX_IRQST   8'h90
`define DTCU_IDX_IRQMSK  8'h91

// Control/status register bit positions
`define DTCU_TCS_TF1     7
`define DTCU_TCS_TR1     6
`define DTCU_TCS_TF0     5
`define DTCU_TCS_TR0     4
`define DTCU_TCS_IE1     3
`define DTCU_TCS_IT1     2
`define DTCU_TCS_IE0     1
`define DTCU_TCS_IT0     0

// Mode register: each nibble is {gate, function select, mode[1:0]}
`define DTCU_TMODE_T1_MSB 7
`define DTCU_TMODE_T1_LSB 4
`define DTCU_TMODE_T0_MSB 3
`define DTCU_TMODE_T0_LSB 0

// Interrupt status/mask bits
`define DTCU_IRQ_OVF0    0
`define DTCU_IRQ_OVF1    1
`define DTCU_IRQ_EXTA    2
`define DTCU_IRQ_EXTB    3

`define DTCU_RST_BYTE    8'h00
`define DTCU_RST_IRQ     4'h0

// One machine cycle is six CPU clocks; the prescaler wraps at five
`define DTCU_MC_CLKS     6
`define DTCU_MC_LAST     3'h5

`endif

// >>> dtcu_pkg.sv
// Types shared by the dual timer/counter unit
package dtcu_pkg;

  typedef enum logic [1:0] {
    DTCU_MODE_13BIT  = 2'b00,
    DTCU_MODE_16BIT  = 2'b01,
    DTCU_MODE_RELOAD = 2'b10,
    DTCU_MODE_SPLIT  = 2'b11
  } dtcu_mode_t;

  typedef struct packed {
    logic       gate;
    logic       ct;
    dtcu_mode_t mode;
  } dtcu_tcfg_t;

  typedef struct packed {
    logic       ovf;
    logic [7:0] th;
    logic [7:0] tl;
  } dtcu_step_t;

endpackage : dtcu_pkg

// >>> dtcu_pin_model.sv
// Far-side model of the count pins and gate pins
`timescale 1ns/1ps
`default_nettype none

module dtcu_pin_model (
  input  wire logic       i_mclk,
  input  wire logic       i_rst,
  input  wire logic       i_start,
  input  wire logic       i_sel,
  input  wire logic [7:0] i_falls,
  input  wire logic [7:0] i_hold,
  input  wire logic [1:0] i_gate_lvl,
  output logic            o_first_count_pin,
  output logic            o_second_count_pin,
  output logic            o_first_gate_pin,
  output logic            o_second_gate_pin,
  output logic            o_busy
);
  logic [1:0] pin_reg;
  logic [8:0] left_reg;
  logic [7:0] hold_reg;

  assign o_first_count_pin  = pin_reg[0];
  assign o_second_count_pin = pin_reg[1];
  assign o_first_gate_pin   = i_gate_lvl[0];
  assign o_second_gate_pin  = i_gate_lvl[1];
  assign o_busy             = (left_reg != 9'h000);

  // Callers keep i_hold at six or more so every level is sampled
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      pin_reg  <= 2'b11;
      left_reg <= 9'h000;
      hold_reg <= 8'h00;
    end else if (i_start) begin
      left_reg <= {i_falls, 1'b0};
      hold_reg <= i_hold;
    end else if (left_reg != 9'h000) begin
      if (hold_reg <= 8'h01) begin
        pin_reg[i_sel] <= ~pin_reg[i_sel];
        left_reg       <= left_reg - 9'h001;
        hold_reg       <= i_hold;
      end else begin
        hold_reg <= hold_reg - 8'h01;
      end
    end
  end
endmodule : dtcu_pin_model
`default_nettype wire

// >>> tb_top.sv
// Self-checking bench for the dual timer/counter unit
`include "dtcu_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  logic        i_mclk = 1'b0;
  logic        i_rst = 1'b1;
  logic [9:0]  address = 10'h000;
  logic        rd_en = 1'b0;
  logic        wr_en = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  be = 4'h0;
  logic [31:0] rdata;
  logic        waitreq;
  logic [3:0]  vec_ack = 4'h0;
  logic        irq, t1_ovf, busy, pin0, pin1, gp0, gp1;
  logic        start = 1'b0;
  logic        sel = 1'b0;
  logic [7:0]  falls = 8'h00;
  logic [7:0]  hold = 8'h06;
  logic [1:0]  gate_lvl = 2'b11;
  logic        wait_q;
  logic [7:0]  rdata_q;
  int          miscompares = 0;
  int          checks_done = 0;
  int          cyc = 0;
  int          ovf_n = 0;

  always #12.5 i_mclk = ~i_mclk;

  // Inputs move only at rising edges, so the falling edge sees settled values
  always @(negedge i_mclk) begin
    wait_q  = waitreq;
    rdata_q = rdata[7:0];
    // The overflow pulse stands one clock, so one falling edge sees it
    if (t1_ovf === 1'b1) begin
      ovf_n++;
    end
  end

  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      $display("mismatch at %0t: run did not finish", $time);
      complete_run();
    end
  end

  dtcu_top i_dtcu_top (
    .i_mclk             (i_mclk),
    .i_rst              (i_rst),
    .i_avs_address      (address),
    .i_avs_read         (rd_en),
    .i_avs_write        (wr_en),
    .i_avs_writedata    (wdata),
    .i_avs_byteenable   (be),
    .o_avs_readdata     (rdata),
    .o_avs_waitrequest  (waitreq),
    .i_first_count_pin  (pin0),
    .i_second_count_pin (pin1),
    .i_first_gate_pin   (gp0),
    .i_second_gate_pin  (gp1),
    .i_vec_ack          (vec_ack),
    .o_irq              (irq),
    .o_second_timer_ovf (t1_ovf)
  );

  dtcu_pin_model i_dtcu_pin_model (
    .i_mclk             (i_mclk),
    .i_rst              (i_rst),
    .i_start            (start),
    .i_sel              (sel),
    .i_falls            (falls),
    .i_hold             (hold),
    .i_gate_lvl         (gate_lvl),
    .o_first_count_pin  (pin0),
    .o_second_count_pin (pin1),
    .o_first_gate_pin   (gp0),
    .o_second_gate_pin  (gp1),
    .o_busy             (busy)
  );

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic bus(input logic w, input logic [7:0] idx,
                     input logic [7:0] d, input logic [3:0] bsel,
                     output logic [7:0] r);
    int n;
    @(posedge i_mclk);
    address <= {idx, 2'b00};
    wdata   <= {24'h000000, d};
    be      <= bsel;
    wr_en   <= w;
    rd_en   <= ~w;
    n = 0;
    do begin
      @(posedge i_mclk);
      n++;
    end while (wait_q !== 1'b0 && n < 50);
    if (n >= 50) begin
      miscompares++;
      $display("mismatch at %0t: no bus answer", $time);
    end
    r = rdata_q;
    wr_en <= 1'b0;
    rd_en <= 1'b0;
  endtask : bus

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] r;
    bus(1'b1, idx, d, 4'h1, r);
  endtask : wr

  task automatic chk(input logic [7:0] idx, input logic [7:0] e,
                     input logic [7:0] m);
    logic [7:0] r;
    bus(1'b0, idx, 8'h00, 4'h0, r);
    check(r & m, e);
  endtask : chk

  task automatic chk_irq(input logic e);
    @(negedge i_mclk);
    check({7'h00, irq}, {7'h00, e});
  endtask : chk_irq

  // Run window spans 60 edges, exactly ten machine cycles in any phase
  task automatic tmr(input logic [7:0] t, md, th, tl, rv, eth, etl, em);
    wr(`DTCU_IDX_TMODE, md);
    wr(`DTCU_IDX_T0HI + t, th);
    wr(`DTCU_IDX_T0LO + t, tl);
    wr(`DTCU_IDX_TCS, rv);
    repeat (57) @(posedge i_mclk);
    wr(`DTCU_IDX_TCS, 8'h00);
    chk(`DTCU_IDX_T0HI + t, eth, 8'hff);
    chk(`DTCU_IDX_T0LO + t, etl, em);
  endtask : tmr

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : complete_run

  initial begin
    int n;
    repeat (20) @(posedge i_mclk);
    i_rst <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      chk(`DTCU_IDX_TCS + 8'(i), 8'h00, 8'hff);
    end
    chk(`DTCU_IDX_IRQST, 8'h00, 8'hff);
    chk(8'h95, 8'h00, 8'hff);
    $display("test reset done");
    tmr(8'h00, 8'h01, 8'h12, 8'h34, 8'h10, 8'h12, 8'h3e, 8'hff);
    $display("test timer mode 1 done");
    wr(`DTCU_IDX_IRQST, 8'h0f);
    tmr(8'h00, 8'h00, 8'hff, 8'h1c, 8'h10, 8'h00, 8'h06, 8'h1f);
    chk(`DTCU_IDX_IRQST, 8'h01, 8'h03);
    wr(`DTCU_IDX_IRQMSK, 8'h01);
    chk_irq(1'b1);
    wr(`DTCU_IDX_IRQMSK, 8'h00);
    chk_irq(1'b0);
    wr(`DTCU_IDX_IRQMSK, 8'h01);
    wr(`DTCU_IDX_IRQST, 8'h01);
    chk_irq(1'b0);
    $display("test mode 0 and interrupt done");
    wr(`DTCU_IDX_IRQST, 8'h0f);
    tmr(8'h00, 8'h02, 8'hf0, 8'hfc, 8'h10, 8'hf0, 8'hf6, 8'hff);
    chk(`DTCU_IDX_IRQST, 8'h01, 8'h03);
    wr(`DTCU_IDX_IRQST, 8'h0f);
    tmr(8'h01, 8'h20, 8'hf0, 8'hfc, 8'h40, 8'hf0, 8'hf6, 8'hff);
    chk(`DTCU_IDX_IRQST, 8'h02, 8'h03);
    check(8'(ovf_n), 8'h01);
    $display("test reload done");
    gate_lvl <= 2'b10;
    tmr(8'h00, 8'h09, 8'h00, 8'h00, 8'h10, 8'h00, 8'h00, 8'hff);
    gate_lvl <= 2'b11;
    tmr(8'h00, 8'h09, 8'h00, 8'h00, 8'h10, 8'h00, 8'h0a, 8'hff);
    $display("test gate done");
    tmr(8'h01, 8'h30, 8'h00, 8'h00, 8'h40, 8'h00, 8'h00, 8'hff);
    wr(`DTCU_IDX_IRQST, 8'h0f);
    tmr(8'h00, 8'h13, 8'hfe, 8'h00, 8'h50, 8'h08, 8'h0a, 8'hff);
    // Timer 1 ran 78 edges since the split began, then halts in mode 3
    wr(`DTCU_IDX_TMODE, 8'h33);
    repeat (30) @(posedge i_mclk);
    chk(`DTCU_IDX_T1LO, 8'h0d, 8'hff);
    chk(`DTCU_IDX_IRQST, 8'h02, 8'h03);
    $display("test split done");
    for (int t = 0; t < 2; t++) begin
      wr(`DTCU_IDX_TMODE, 8'h05 << (4 * t));
      wr(`DTCU_IDX_T0HI + 8'(t), 8'h00);
      wr(`DTCU_IDX_T0LO + 8'(t), 8'h00);
      wr(`DTCU_IDX_TCS, 8'h10 << (2 * t));
      @(posedge i_mclk);
      sel   <= t[0];
      falls <= 8'h07;
      hold  <= (t == 0) ? 8'h0d : 8'h06;
      start <= 1'b1;
      @(posedge i_mclk);
      start <= 1'b0;
      n = 0;
      do begin
        @(posedge i_mclk);
        n++;
      end while (busy && n < 600);
      repeat (24) @(posedge i_mclk);
      wr(`DTCU_IDX_TCS, 8'h00);
      chk(`DTCU_IDX_T0LO + 8'(t), 8'h07, 8'hff);
      chk(`DTCU_IDX_T0HI + 8'(t), 8'h00, 8'hff);
    end
    $display("test counter done");
    bus(1'b1, `DTCU_IDX_T0LO, 8'h55, 4'h0, falls);
    chk(`DTCU_IDX_T0LO, 8'h07, 8'hff);
    for (int t = 0; t < 2; t++) begin
      wr(`DTCU_IDX_TCS, 8'h20 << (2 * t));
      chk(`DTCU_IDX_TCS, 8'h20 << (2 * t), 8'hff);
      @(posedge i_mclk);
      vec_ack <= 4'h1 << t;
      @(posedge i_mclk);
      vec_ack <= 4'h0;
      chk(`DTCU_IDX_TCS, 8'h00, 8'ha0);
    end
    $display("test vector clear done");
    complete_run();
  end
endmodule : tb_top
`default_nettype wire
